// ===== lbr_consts.svh
// Register offsets, field positions and reset values of the break receiver.
`ifndef LBR_CONSTS_SVH
`define LBR_CONSTS_SVH
`define LBR_OFS_MODE  8'h00
`define LBR_OFS_CTL   8'h04
`define LBR_OFS_ERR   8'h08
`define LBR_OFS_BUF   8'h0C
`define LBR_OFS_DIV   8'h10
`define LBR_OFS_IST   8'h14
`define LBR_OFS_MSK   8'h18
`define LBR_MODE_PWR  7
`define LBR_MODE_RXE  5
`define LBR_MODE_PAR  2
`define LBR_MODE_WMSK 8'hA4
`define LBR_CTL_BRF   7
`define LBR_CTL_BRT   6
`define LBR_ERR_OVE   0
`define LBR_ERR_FE    1
`define LBR_ERR_PE    2
`define LBR_IRQ_DONE  0
`define LBR_IRQ_ERR   1
`define LBR_BUF_RST   8'hFF
`define LBR_BRK_MIN   4'hB
`define LBR_BRK_SAT   4'hF
`define LBR_LAST_BIT  4'h7
`define LBR_DIV_RST   16'h0010
`endif

// ===== lbr_lin_node.sv
// Remote LIN node model that drives the serial line of the receiver.
`timescale 1ns/10ps
module lbr_lin_node (
    // Clock that paces the bit periods.
    input  wire logic hclk,
    // Serial line, recessive high whenever no frame is sent.
    output logic      serial_receive_pin
);
    initial serial_receive_pin = 1'b1;

    // Must be entered just after a rising edge, so the line moves off it.
    task automatic hold_bits(input logic lvl, input int n, input int div);
        serial_receive_pin <= lvl;
        repeat (n * div) @(posedge hclk);
    endtask

    // A break is a low period of whole bit times, then a recessive gap.
    task automatic send_break(input int n, input int div);
        @(posedge hclk);
        hold_bits(1'b0, n, div);
        hold_bits(1'b1, 3, div);
    endtask

    // The gap of three bits lets the receiver finish before the next frame.
    task automatic send_byte(input logic [7:0] d, input logic stp,
                             input int div);
        int i;
        @(posedge hclk);
        hold_bits(1'b0, 1, div);
        for (i = 0; i < 8; i++) begin
            hold_bits(d[i], 1, div);
        end
        hold_bits(stp, 1, div);
        hold_bits(1'b1, 3, div);
    endtask
endmodule

// ===== lbr_pkg.sv
// Types shared by the break receiver.
package lbr_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       vld;
    } lbr_aphase_type;
    typedef enum logic [2:0] {
        S_IDLE, S_START, S_DATA, S_PAR, S_STOP, S_BRK
    } lbr_state_type;
endpackage

// ===== lbr_rx.sv
// Serial receiver with break-field reception behind an AHB-Lite slave.
// Summary of operation
// - Trigger bit write enters break reception.
// - Break mode detects start bit normally.
// - Shift bits in at programmed baud.
// - Break of 11+ bits raises completion interrupt.
// - Valid break clears flag and trigger.
// - Break mode suppresses all error flags.
// - Break mode never loads receive buffer.
// - Short break: no interrupt, re-arm.
// - Short break leaves flag and trigger set.
// - Flag bit 7, trigger bit 6.
`timescale 1ns/10ps
`include "lbr_consts.svh"
module lbr_rx #(
    parameter int         DIV_W   = 16,
    parameter [DIV_W-1:0] DIV_RST = `LBR_DIV_RST
) (
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Serial line and interrupt.
    input  wire logic        serial_receive_pin,
    output logic             receive_complete_irq
);
    generate
        if (DIV_W < 4 || DIV_W > 16) begin : g_chk
            $error("DIV_W must lie between 4 and 16");
        end
    endgenerate

    lbr_pkg::lbr_aphase_type ap_q;
    lbr_pkg::lbr_state_type  state_q;
    logic             rx_s1_q;
    logic             rx_s2_q;
    logic [7:0]       serial_mode_register;
    logic             rx_en_q;
    logic             break_receive_trigger;
    logic             break_receive_flag;
    logic [2:0]       receive_error_status;
    logic [7:0]       receive_buffer_register;
    logic             full_q;
    logic [DIV_W-1:0] div_q;
    logic [1:0]       ist_q;
    logic [1:0]       msk_q;
    logic [DIV_W-1:0] cnt_q;
    logic [3:0]       bit_q;
    logic [7:0]       receive_shift_register;
    logic             pe_q;
    logic             hready_q;
    logic             hresp_q;
    logic [31:0]      hrdata_q;
    logic             irq_q;

    assign hreadyout            = hready_q;
    assign hresp                = hresp_q;
    assign hrdata               = hrdata_q;
    assign receive_complete_irq = irq_q;

    // Bus decode: writes act in the data phase, reads are latched at
    // the address phase so that the answer comes with no wait state.
    wire       a_take = hsel & hready & htrans[1];
    wire       a_rd   = a_take & ~hwrite;
    wire [7:0] a_ofs  = haddr[7:0];
    wire       wr     = ap_q.vld & ap_q.wr;
    wire       wr_mode = wr & (ap_q.addr == `LBR_OFS_MODE);
    wire       wr_ctl  = wr & (ap_q.addr == `LBR_OFS_CTL);
    wire       wr_err  = wr & (ap_q.addr == `LBR_OFS_ERR);
    wire       wr_div  = wr & (ap_q.addr == `LBR_OFS_DIV);
    wire       wr_ist  = wr & (ap_q.addr == `LBR_OFS_IST);
    wire       wr_msk  = wr & (ap_q.addr == `LBR_OFS_MSK);
    wire       buf_rd  = a_rd & (a_ofs == `LBR_OFS_BUF);

    wire [7:0] ctl_rd = {break_receive_flag, break_receive_trigger,
                         6'h00};
    wire [31:0] rdata_d =
        (a_ofs == `LBR_OFS_MODE) ? {24'h000000, serial_mode_register} :
        (a_ofs == `LBR_OFS_CTL)  ? {24'h000000, ctl_rd} :
        (a_ofs == `LBR_OFS_ERR)  ? {29'h00000000, receive_error_status} :
        (a_ofs == `LBR_OFS_BUF)  ? {24'h000000, receive_buffer_register} :
        (a_ofs == `LBR_OFS_DIV)  ? {{(32-DIV_W){1'b0}}, div_q} :
        (a_ofs == `LBR_OFS_IST)  ? {30'h00000000, ist_q} :
        (a_ofs == `LBR_OFS_MSK)  ? {30'h00000000, msk_q} :
        32'h00000000;

    // Receiver timing: cnt_q counts down to the next mid-bit sample.
    wire tick     = (cnt_q == '0);
    wire brk_mode = break_receive_trigger;
    wire in_brk   = (state_q == lbr_pkg::S_BRK);
    wire brk_end  = in_brk & tick & rx_s2_q;
    wire brk_ok   = brk_end & (bit_q >= `LBR_BRK_MIN);
    wire brk_short = brk_end & (bit_q < `LBR_BRK_MIN);
    wire norm_done = (state_q == lbr_pkg::S_STOP) & tick;
    wire ove_d    = full_q & ~buf_rd;
    wire [2:0] err_new;
    assign err_new[`LBR_ERR_OVE] = ove_d;
    assign err_new[`LBR_ERR_FE]  = ~rx_s2_q;
    assign err_new[`LBR_ERR_PE]  = pe_q;
    wire any_err = |err_new;

    // Mode register and the ordered enable: the receiver runs only when
    // power was already on before the enable bit rose.
    wire [7:0] mode_d = wr_mode ? (hwdata[7:0] & `LBR_MODE_WMSK)
                                : serial_mode_register;
    wire uart_power_on      = mode_d[`LBR_MODE_PWR];
    wire receive_enable_bit = mode_d[`LBR_MODE_RXE];
    // The old enable bit must be clear, or a single write that set both
    // bits would still enable the receiver one cycle later.
    wire rx_en_d = uart_power_on & receive_enable_bit &
        (rx_en_q | (serial_mode_register[`LBR_MODE_PWR] &
        ~serial_mode_register[`LBR_MODE_RXE]));

    // Trigger write sets both flag and trigger; set wins over the
    // automatic clear of a valid break.
    wire trig_wr  = wr_ctl & hwdata[`LBR_CTL_BRT];
    wire brt_d = trig_wr | (~wr_ctl & ~brk_ok & break_receive_trigger);
    wire brf_d = trig_wr | (~wr_ctl & ~brk_ok & break_receive_flag);

    wire [1:0] ev;
    assign ev[`LBR_IRQ_DONE] = norm_done | brk_ok;
    assign ev[`LBR_IRQ_ERR]  = norm_done & any_err;
    wire [1:0] ist_d = ev | (ist_q & ~({2{wr_ist}} & hwdata[1:0]));

    wire [2:0] err_set = norm_done ? err_new : 3'h0;
    wire [2:0] err_d = err_set |
        (receive_error_status & ~({3{wr_err}} & hwdata[2:0]));

    wire buf_ld = norm_done & ~ove_d;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
        end else begin
            rx_s1_q <= serial_receive_pin;
            rx_s2_q <= rx_s1_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_q     <= '0;
            hready_q <= 1'b1;
            hresp_q  <= 1'b0;
            hrdata_q <= 32'h00000000;
        end else begin
            ap_q <= '{addr: a_ofs, wr: hwrite, vld: a_take};
            if (a_rd) begin
                hrdata_q <= rdata_d;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_mode_register  <= 8'h00;
            rx_en_q               <= 1'b0;
            break_receive_trigger <= 1'b0;
            break_receive_flag    <= 1'b0;
            div_q                 <= DIV_RST;
            msk_q                 <= 2'h0;
            ist_q                 <= 2'h0;
            irq_q                 <= 1'b0;
        end else begin
            serial_mode_register  <= mode_d;
            rx_en_q               <= rx_en_d;
            break_receive_trigger <= brt_d;
            break_receive_flag    <= brf_d;
            if (wr_div) begin
                div_q <= hwdata[DIV_W-1:0];
            end
            if (wr_msk) begin
                msk_q <= hwdata[1:0];
            end
            ist_q <= ist_d;
            irq_q <= |(ist_d & msk_q);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            receive_error_status    <= 3'h0;
            receive_buffer_register <= `LBR_BUF_RST;
            full_q                  <= 1'b0;
        end else begin
            receive_error_status <= err_d;
            if (buf_ld) begin
                receive_buffer_register <= receive_shift_register;
            end
            full_q <= buf_ld | (full_q & ~buf_rd);
        end
    end

    // Receive state machine. A divisor below three gives no mid-bit
    // sample, so software must program at least three.
    wire [DIV_W-1:0] full_bit = div_q - 1'b1;
    wire [DIV_W-1:0] half_bit = div_q >> 1;
    wire [3:0]       bit_inc  = bit_q + 4'h1;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q                <= lbr_pkg::S_IDLE;
            cnt_q                  <= '0;
            bit_q                  <= 4'h0;
            receive_shift_register <= 8'h00;
            pe_q                   <= 1'b0;
        end else if (!rx_en_q) begin
            state_q <= lbr_pkg::S_IDLE;
        end else begin
            if (!tick) begin
                cnt_q <= cnt_q - 1'b1;
            end
            case (state_q)
                lbr_pkg::S_IDLE: begin
                    if (!rx_s2_q) begin
                        state_q <= lbr_pkg::S_START;
                        cnt_q   <= half_bit;
                    end
                end
                lbr_pkg::S_START: begin
                    if (tick) begin
                        cnt_q <= full_bit;
                        pe_q  <= 1'b0;
                        if (rx_s2_q) begin
                            state_q <= lbr_pkg::S_IDLE;
                        end else if (brk_mode) begin
                            state_q <= lbr_pkg::S_BRK;
                            bit_q   <= 4'h1;
                        end else begin
                            state_q <= lbr_pkg::S_DATA;
                            bit_q   <= 4'h0;
                        end
                    end
                end
                lbr_pkg::S_DATA: begin
                    if (tick) begin
                        cnt_q <= full_bit;
                        receive_shift_register <=
                            {rx_s2_q, receive_shift_register[7:1]};
                        bit_q <= bit_inc;
                        if (bit_q == `LBR_LAST_BIT) begin
                            state_q <= serial_mode_register[`LBR_MODE_PAR]
                                       ? lbr_pkg::S_PAR : lbr_pkg::S_STOP;
                        end
                    end
                end
                lbr_pkg::S_PAR: begin
                    if (tick) begin
                        cnt_q   <= full_bit;
                        pe_q    <= rx_s2_q ^ (^receive_shift_register);
                        state_q <= lbr_pkg::S_STOP;
                    end
                end
                lbr_pkg::S_STOP: begin
                    if (tick) begin
                        state_q <= lbr_pkg::S_IDLE;
                    end
                end
                lbr_pkg::S_BRK: begin
                    if (tick) begin
                        cnt_q <= full_bit;
                        receive_shift_register <=
                            {rx_s2_q, receive_shift_register[7:1]};
                        if (rx_s2_q) begin
                            state_q <= lbr_pkg::S_IDLE;
                        end else if (bit_q != `LBR_BRK_SAT) begin
                            bit_q <= bit_inc;
                        end
                    end
                end
                default: begin
                    state_q <= lbr_pkg::S_IDLE;
                end
            endcase
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    en_order_a: assert property ($rose(rx_en_q) |->
        $past(serial_mode_register[`LBR_MODE_PWR] &&
        !serial_mode_register[`LBR_MODE_RXE]))
        else $error("receiver enabled without power set first");
    trig_set_a: assert property (trig_wr |=>
        break_receive_trigger && break_receive_flag)
        else $error("trigger write did not arm break mode");
    start_det_a: assert property (state_q == lbr_pkg::S_IDLE && rx_en_q &&
        !rx_s2_q |=> state_q == lbr_pkg::S_START)
        else $error("start bit not detected");
    shift_in_a: assert property ((state_q == lbr_pkg::S_DATA ||
        in_brk) && tick && rx_en_q |=>
        receive_shift_register[7] == $past(rx_s2_q))
        else $error("sample not shifted in");
    brk_irq_a: assert property (brk_ok |=> ist_q[`LBR_IRQ_DONE])
        else $error("valid break raised no completion event");
    brk_clear_a: assert property (brk_ok && !wr_ctl |=>
        !break_receive_trigger && !break_receive_flag)
        else $error("valid break left control bits set");
    no_err_a: assert property (in_brk && !wr_err |=>
        $stable(receive_error_status))
        else $error("error status changed in break mode");
    buf_keep_a: assert property (in_brk |=>
        $stable(receive_buffer_register))
        else $error("buffer loaded in break mode");
    short_irq_a: assert property (brk_short && !wr_ist |=>
        $stable(ist_q) ##1 state_q == lbr_pkg::S_IDLE)
        else $error("short break raised an event or did not re-arm");
    short_keep_a: assert property (brk_short && !wr_ctl |=>
        break_receive_trigger && break_receive_flag)
        else $error("short break cleared control bits");
    ctl_read_a: assert property (a_rd && a_ofs == `LBR_OFS_CTL |=>
        hrdata_q[7:6] == $past({break_receive_flag,
        break_receive_trigger}))
        else $error("control bits read at wrong positions");
    brk_count_a: assert property (in_brk && tick && rx_en_q && !rx_s2_q &&
        bit_q != `LBR_BRK_SAT |=> bit_q == $past(bit_q) + 4'h1)
        else $error("break width not counted");

    brk_ok_c: cover property (brk_ok);
    brk_short_c: cover property (brk_short);
    norm_err_c: cover property (norm_done && any_err);
endmodule

// ===== lbr_rx_tb_top.sv
// Self-checking testbench of the break receiver.
`timescale 1ns/10ps
`include "lbr_consts.svh"
module lbr_rx_tb_top;
    localparam int          DIV   = 16;
    localparam logic [31:0] BRT   = 32'h1 << `LBR_CTL_BRT;
    localparam logic [31:0] ARMED = BRT | (32'h1 << `LBR_CTL_BRF);
    localparam logic [31:0] DONE  = 32'h1 << `LBR_IRQ_DONE;
    localparam logic [31:0] PWR   = 32'h1 << `LBR_MODE_PWR;
    localparam logic [31:0] EN    = PWR | (32'h1 << `LBR_MODE_RXE);
    localparam logic [31:0] PAR   = 32'h1 << `LBR_MODE_PAR;
    localparam logic [31:0] PE    = 32'h1 << `LBR_ERR_PE;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        serial_receive_pin;
    logic        receive_complete_irq;
    int          bad_count;
    int          checks;

    lbr_rx u_dut (
        .hclk                 (hclk),
        .hresetn              (hresetn),
        .hsel                 (hsel),
        .haddr                (haddr),
        .htrans               (htrans),
        .hwrite               (hwrite),
        .hsize                (hsize),
        .hwdata               (hwdata),
        .hready               (hreadyout),
        .hreadyout            (hreadyout),
        .hresp                (hresp),
        .hrdata               (hrdata),
        .serial_receive_pin   (serial_receive_pin),
        .receive_complete_irq (receive_complete_irq)
    );

    lbr_lin_node u_node (
        .hclk               (hclk),
        .serial_receive_pin (serial_receive_pin)
    );

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic addr_ph(input logic [7:0] a, input logic w);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_ph(a, 1'b1);
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    // Read data stands until the next read, so it is taken at this edge.
    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input string what);
        addr_ph(a, 1'b0);
        do @(posedge hclk); while (hreadyout !== 1'b1);
        chk(hrdata, exp, what);
        chk({31'h0, hresp}, 32'h0, "hresp okay");
    endtask

    // The interrupt output changes with the status, but follows a mask write one cycle later.
    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge hclk);
        chk({31'h0, receive_complete_irq}, {31'h0, exp}, "irq");
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        bad_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        report_and_stop;
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        bad_count = 0;
        checks = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rd(`LBR_OFS_MODE, 32'h0, "mode reset");
        rd(`LBR_OFS_CTL, 32'h0, "ctl reset");
        rd(`LBR_OFS_BUF, 32'hFF, "buf reset");
        rd(`LBR_OFS_DIV, {16'h0, `LBR_DIV_RST}, "div reset");
        rd(8'h1C, 32'h0, "unmapped");
        $display("test done: reset values");
        // Power and enable in one write must leave the receiver deaf.
        wr(`LBR_OFS_MODE, EN);
        wr(`LBR_OFS_CTL, BRT);
        rd(`LBR_OFS_CTL, ARMED, "armed");
        u_node.send_break(11, DIV);
        rd(`LBR_OFS_IST, 32'h0, "deaf ist");
        rd(`LBR_OFS_CTL, ARMED, "deaf ctl");
        $display("test done: enable order");
        wr(`LBR_OFS_MODE, PWR);
        wr(`LBR_OFS_MODE, EN);
        u_node.send_break(10, DIV);
        rd(`LBR_OFS_IST, 32'h0, "short ist");
        rd(`LBR_OFS_CTL, ARMED, "short ctl");
        wr(`LBR_OFS_MSK, DONE);
        irq_chk(1'b0);
        wr(`LBR_OFS_MSK, 32'h0);
        $display("test done: short break");
        // No re-arm here: a short break must have left it waiting.
        u_node.send_break(11, DIV);
        rd(`LBR_OFS_IST, DONE, "break ist");
        rd(`LBR_OFS_CTL, 32'h0, "break ctl");
        rd(`LBR_OFS_ERR, 32'h0, "break err");
        rd(`LBR_OFS_BUF, 32'hFF, "break buf");
        irq_chk(1'b0);
        wr(`LBR_OFS_MSK, DONE);
        irq_chk(1'b1);
        wr(`LBR_OFS_IST, DONE);
        irq_chk(1'b0);
        $display("test done: valid break");
        u_node.send_byte(8'h5A, 1'b1, DIV);
        rd(`LBR_OFS_BUF, 32'h5A, "byte buf");
        rd(`LBR_OFS_ERR, 32'h0, "byte err");
        irq_chk(1'b1);
        u_node.send_byte(8'h3C, 1'b0, DIV);
        rd(`LBR_OFS_ERR, 32'h1 << `LBR_ERR_FE, "frame err");
        rd(`LBR_OFS_BUF, 32'h3C, "frame buf");
        $display("test done: normal frames");
        // The stop argument lands in the parity slot; the gap is the stop.
        wr(`LBR_OFS_ERR, 32'h7);
        wr(`LBR_OFS_IST, 32'h3);
        wr(`LBR_OFS_MODE, EN | PAR);
        u_node.send_byte(8'h5A, 1'b1, DIV);
        rd(`LBR_OFS_ERR, PE, "parity err");
        rd(`LBR_OFS_IST, 32'h3, "parity ist");
        rd(`LBR_OFS_BUF, 32'h5A, "parity buf");
        $display("test done: parity frame");
        report_and_stop;
    end
endmodule
